// File: verilog/mlm_cfg.svh
// register map, field positions, reset values and fixed-point format of the mixer
`ifndef MLM_CFG_SVH
`define MLM_CFG_SVH

// register word addresses
`define MLM_A_CTRL 8'h00
`define MLM_A_LOOPBACK 8'h01
`define MLM_A_MS 8'h02
`define MLM_A_SUBMIX 8'h03
`define MLM_A_STATUS 8'h04
`define MLM_A_DMON 8'h05
`define MLM_A_IEQ 8'h10
`define MLM_A_OEQ 8'h20
`define MLM_A_GAIN 8'h40

// control and command fields
`define MLM_B_IPR 0
`define MLM_B_COPY 8
`define MLM_B_CLEAR 9
`define MLM_F_SRC 0
`define MLM_F_DST 4
`define MLM_F_IDXW 4
`define MLM_F_DM_PAN 16
`define MLM_F_DM_SRC 24
`define MLM_F_DM_PAIR 28

// sample and gain format: gains are signed q1.14, unity at 0x4000
`define MLM_SW 24
`define MLM_GW 16
`define MLM_GAIN_FRAC 14
`define MLM_UNITY 16'h4000
`define MLM_PAN_MAX 8'hff
`define MLM_PAN_SHIFT 8

// structural defaults
`define MLM_NI 4
`define MLM_NP 4
`define MLM_NO 6

`endif

// File: verilog/mlm_pkg.sv
// shared types and arithmetic helpers of the mixer datapath
package mlm_pkg;
  `include "mlm_cfg.svh"

  typedef logic signed [`MLM_SW-1:0] mlm_sample_t;
  typedef logic signed [`MLM_GW-1:0] mlm_gain_t;
  typedef logic signed [`MLM_SW+`MLM_GW:0] mlm_acc_t;
  typedef enum logic [1:0] {MLM_OP_NONE, MLM_OP_COPY, MLM_OP_CLEAR, MLM_OP_DMON} mlm_op_t;

  // product of a sample and a q1.14 gain, kept wide for accumulation
  function automatic mlm_acc_t mlm_mul(input mlm_sample_t s, input mlm_gain_t g);
    logic signed [`MLM_SW+`MLM_GW-1:0] p;
    p = s * g;
    return mlm_acc_t'(p >>> `MLM_GAIN_FRAC);
  endfunction

  // clip a wide value back to sample range instead of wrapping
  function automatic mlm_sample_t mlm_sat(input mlm_acc_t a);
    mlm_sample_t mx;
    mlm_sample_t mn;
    mx = {1'b0, {(`MLM_SW-1){1'b1}}};
    mn = {1'b1, {(`MLM_SW-1){1'b0}}};
    if (a > mlm_acc_t'(mx)) return mx;
    if (a < mlm_acc_t'(mn)) return mn;
    return a[`MLM_SW-1:0];
  endfunction
endpackage

// File: verilog/mlm_ms_pair.sv
// mid/side matrix for one channel pair; the same sum/difference both encodes and decodes
`timescale 1ns/10ps
module mlm_ms_pair (
  input wire logic en, // matrix on for this pair
  input mlm_pkg::mlm_sample_t a_l, // left or mid in
  input mlm_pkg::mlm_sample_t a_r, // right or side in
  output mlm_pkg::mlm_sample_t y_l, // left out
  output mlm_pkg::mlm_sample_t y_r // right out
);
  mlm_pkg::mlm_acc_t sum;
  mlm_pkg::mlm_acc_t dif;

  // mid to both sides, side added left and inverted right; on plain stereo this
  // leaves the sum on the left and the difference on the right
  always_comb begin
    sum = mlm_pkg::mlm_acc_t'(a_l) + mlm_pkg::mlm_acc_t'(a_r);
    dif = mlm_pkg::mlm_acc_t'(a_l) - mlm_pkg::mlm_acc_t'(a_r);
    y_l = en ? mlm_pkg::mlm_sat(sum) : a_l;
    y_r = en ? mlm_pkg::mlm_sat(dif) : a_r;
  end
endmodule

// File: verilog/mlm_mixer.sv
// crosspoint mixer with per-output loopback to the record path and mid/side matrix
// Function
// - loopback records the mixed output instead
// - loopback input still feeds the mixer
// - one loopback enable per output channel that has a record channel
// - every output with a record channel may loop back, inputs kept
// - output equaliser lies in looped record path
// - looped record path includes input equaliser
// - headphone outputs never loop back
// - mid to both, side inverted on right
// - mid/side enable per input and playback pair
// - same matrix encodes plain stereo to sum/difference
// - copy submix replicates all source gains
// - clear submix removes routings of output
// - host gain and pan applied at once
// - individual gain at every crosspoint
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "mlm_cfg.svh"
module mlm_mixer #(
  parameter int NI = `MLM_NI,
  parameter int NP = `MLM_NP,
  parameter int NO = `MLM_NO
) (
  input wire logic clk, // 250 mhz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [7:0] addr, // register word address
  input wire logic [31:0] wr_data, // register write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [31:0] rd_data, // read data, cycle after rd_en
  input wire logic in_valid, // sample boundary strobe
  input wire logic [NI-1:0][`MLM_SW-1:0] in_data, // hardware inputs
  input wire logic [NP-1:0][`MLM_SW-1:0] pb_data, // host playback channels
  output logic out_valid, // outputs and record valid
  output logic [NO-1:0][`MLM_SW-1:0] out_data, // hardware outputs
  output logic [NI-1:0][`MLM_SW-1:0] rec_data // record channels to host
);
  localparam int NS = NI + NP;
  localparam int NX = NO * NS;
  localparam int NPR = NS / 2;
  // only outputs with a matching record channel can loop back; the rest are phones
  localparam logic [NO-1:0] LB_MASK = {{(NO-NI){1'b0}}, {NI{1'b1}}};

  typedef struct packed {
    logic [NX-1:0][`MLM_GW-1:0] gain_p;
    logic [NX-1:0][`MLM_GW-1:0] gain_l;
    logic [NI-1:0][`MLM_GW-1:0] ieq;
    logic [NO-1:0][`MLM_GW-1:0] oeq;
    logic [NO-1:0] lb_p;
    logic [NO-1:0] lb_l;
    logic [NPR-1:0] ms_en;
    logic ipr;
    logic [NS-1:0][`MLM_SW-1:0] src;
    logic [NI-1:0][`MLM_SW-1:0] irec;
    logic v1;
    logic [NO-1:0][`MLM_SW-1:0] out;
    logic [NI-1:0][`MLM_SW-1:0] rec;
    logic ov;
    logic [31:0] rd;
    mlm_pkg::mlm_op_t op;
    logic [15:0] cnt;
  } mlm_state_t;

  mlm_state_t st_q;
  mlm_state_t st_d;
  logic [NS-1:0][`MLM_SW-1:0] src_raw;
  logic [NS-1:0][`MLM_SW-1:0] ms_out;

  // address window decode, shared by the write and read sides
  function automatic logic in_rng(input logic [7:0] a, input logic [7:0] base, input int n);
    return (a >= base) && (int'(a - base) < n);
  endfunction

  // one share of a panned gain: g * w / 256
  function automatic mlm_pkg::mlm_gain_t pan_part(input logic [15:0] g, input logic [7:0] w);
    logic signed [25:0] p;
    p = $signed(g) * $signed({1'b0, w});
    return p[`MLM_PAN_SHIFT +: `MLM_GW];
  endfunction

  // sources: inputs first, then playback; each adjacent pair has its own matrix
  for (genvar s = 0; s < NS; s++) begin : g_src
    if (s < NI) begin : g_in
      assign src_raw[s] = in_data[s];
    end else begin : g_pb
      assign src_raw[s] = pb_data[s-NI];
    end
  end
  for (genvar p = 0; p < NPR; p++) begin : g_ms
    mlm_ms_pair u_ms (
      .en(st_q.ms_en[p]),
      .a_l(src_raw[2*p]),
      .a_r(src_raw[2*p+1]),
      .y_l(ms_out[2*p]),
      .y_r(ms_out[2*p+1])
    );
  end

  // next state: register writes, reads, then the two-stage sample pipeline
  always_comb begin
    logic [`MLM_F_IDXW-1:0] si;
    logic [`MLM_F_IDXW-1:0] di;
    logic [`MLM_F_IDXW-1:0] dp;
    logic [7:0] pan;
    logic [NO-1:0][`MLM_SW-1:0] mixv;
    logic [NS-1:0][`MLM_SW-1:0] eqv;
    mlm_pkg::mlm_acc_t acc;
    si = wr_data[`MLM_F_SRC +: `MLM_F_IDXW];
    di = wr_data[`MLM_F_DST +: `MLM_F_IDXW];
    dp = wr_data[`MLM_F_DM_PAIR +: `MLM_F_IDXW];
    pan = wr_data[`MLM_F_DM_PAN +: 8];
    mixv = '0;
    eqv = '0;
    acc = '0;
    st_d = st_q;
    st_d.rd = 32'h0;

    // gain and loopback writes land in the pending copy; the live copy follows at the next sample
    if (wr_en) begin
      case (addr)
        `MLM_A_CTRL: st_d.ipr = wr_data[`MLM_B_IPR];
        `MLM_A_LOOPBACK: st_d.lb_p = wr_data[NO-1:0] & LB_MASK;
        `MLM_A_MS: st_d.ms_en = wr_data[NPR-1:0];
        `MLM_A_SUBMIX: begin
          if (wr_data[`MLM_B_COPY] && int'(si) < NO && int'(di) < NO) begin
            for (int s = 0; s < NS; s++) begin
              st_d.gain_p[int'(di)*NS+s] = st_q.gain_p[int'(si)*NS+s];
            end
            st_d.op = mlm_pkg::MLM_OP_COPY;
          end
          // clear after copy, so a command with both bits leaves the target empty
          if (wr_data[`MLM_B_CLEAR] && int'(di) < NO) begin
            for (int s = 0; s < NS; s++) begin
              st_d.gain_p[int'(di)*NS+s] = '0;
            end
            st_d.op = mlm_pkg::MLM_OP_CLEAR;
          end
        end
        `MLM_A_DMON: begin
          // gain split over the left and right crosspoints of one output pair
          if (int'(wr_data[`MLM_F_DM_SRC +: 4]) < NS && 2*int'(dp)+1 < NO) begin
            st_d.gain_p[2*int'(dp)*NS+int'(wr_data[`MLM_F_DM_SRC +: 4])] =
              pan_part(wr_data[`MLM_GW-1:0], `MLM_PAN_MAX - pan);
            st_d.gain_p[(2*int'(dp)+1)*NS+int'(wr_data[`MLM_F_DM_SRC +: 4])] =
              pan_part(wr_data[`MLM_GW-1:0], pan);
            st_d.op = mlm_pkg::MLM_OP_DMON;
          end
        end
        default: begin
          if (in_rng(addr, `MLM_A_GAIN, NX)) begin
            st_d.gain_p[addr-`MLM_A_GAIN] = wr_data[`MLM_GW-1:0];
          end else if (in_rng(addr, `MLM_A_IEQ, NI)) begin
            st_d.ieq[addr-`MLM_A_IEQ] = wr_data[`MLM_GW-1:0];
          end else if (in_rng(addr, `MLM_A_OEQ, NO)) begin
            st_d.oeq[addr-`MLM_A_OEQ] = wr_data[`MLM_GW-1:0];
          end
        end
      endcase
    end

    // reads answer in the next cycle only; unmapped words read as zero
    if (rd_en) begin
      case (addr)
        `MLM_A_CTRL: st_d.rd = 32'(st_q.ipr);
        `MLM_A_LOOPBACK: st_d.rd = 32'(st_q.lb_p);
        `MLM_A_MS: st_d.rd = 32'(st_q.ms_en);
        `MLM_A_STATUS: st_d.rd = {14'h0, st_q.op, st_q.cnt};
        default: begin
          if (in_rng(addr, `MLM_A_GAIN, NX)) begin
            st_d.rd = 32'(st_q.gain_p[addr-`MLM_A_GAIN]);
          end else if (in_rng(addr, `MLM_A_IEQ, NI)) begin
            st_d.rd = 32'(st_q.ieq[addr-`MLM_A_IEQ]);
          end else if (in_rng(addr, `MLM_A_OEQ, NO)) begin
            st_d.rd = 32'(st_q.oeq[addr-`MLM_A_OEQ]);
          end
        end
      endcase
    end

    // stage 1 at the sample boundary: matrix, input eq, latch live settings
    // playback has no input eq, so only the first NI sources are scaled
    for (int s = 0; s < NS; s++) begin
      eqv[s] = ms_out[s];
    end
    for (int s = 0; s < NI; s++) begin
      eqv[s] = mlm_pkg::mlm_sat(mlm_pkg::mlm_mul(ms_out[s], st_q.ieq[s]));
    end
    st_d.v1 = in_valid;
    if (in_valid) begin
      // whole gain set swapped at once, so no sample sees a half-applied change
      st_d.gain_l = st_q.gain_p;
      st_d.lb_l = st_q.lb_p;
      st_d.cnt = st_q.cnt + 16'h1;
      st_d.src = eqv;
      for (int i = 0; i < NI; i++) begin
        st_d.irec[i] = st_q.ipr ? eqv[i] : in_data[i];
      end
    end

    // stage 2: mix every source through its own gain, then the output eq
    st_d.ov = st_q.v1;
    for (int o = 0; o < NO; o++) begin
      acc = '0;
      for (int s = 0; s < NS; s++) begin
        acc = acc + mlm_pkg::mlm_mul(st_q.src[s], st_q.gain_l[o*NS+s]);
      end
      mixv[o] = mlm_pkg::mlm_sat(mlm_pkg::mlm_mul(mlm_pkg::mlm_sat(acc), st_q.oeq[o]));
    end
    if (st_q.v1) begin
      st_d.out = mixv;
      for (int i = 0; i < NI; i++) begin
        // looped channels take the equalised output, which already carries the input eq
        st_d.rec[i] = st_q.lb_l[i] ? mixv[i] : st_q.irec[i];
      end
    end
  end

  // single state register; eq gains come up at unity so audio passes after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.ieq <= {NI{`MLM_UNITY}};
      st_q.oeq <= {NO{`MLM_UNITY}};
      st_q.op <= mlm_pkg::MLM_OP_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign rd_data = st_q.rd;
  assign out_valid = st_q.ov;
  assign out_data = st_q.out;
  assign rec_data = st_q.rec;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_sample;
    in_valid ##1 st_q.v1;
  endsequence

  property p_pipe;
    in_valid |-> s_sample ##1 out_valid;
  endproperty
  a_pipe: assert property (p_pipe) else $error("sample not out after two cycles");

  property p_lb_rec;
    out_valid && $past(st_q.lb_l[0]) |-> rec_data[0] == out_data[0];
  endproperty
  a_lb_rec: assert property (p_lb_rec) else $error("looped record differs from output");

  property p_in_rec;
    in_valid && !st_q.lb_p[0] && !st_q.ipr && !wr_en |=> ##1 rec_data[0] == $past(in_data[0], 2);
  endproperty
  a_in_rec: assert property (p_in_rec) else $error("record lost the raw input");

  property p_lb_wr;
    wr_en && addr == `MLM_A_LOOPBACK |=> st_q.lb_p == ($past(wr_data[NO-1:0]) & LB_MASK);
  endproperty
  a_lb_wr: assert property (p_lb_wr) else $error("loopback enable not stored");

  property p_phones;
    (st_q.lb_p & ~LB_MASK) == '0 && (st_q.lb_l & ~LB_MASK) == '0;
  endproperty
  a_phones: assert property (p_phones) else $error("phones loopback enabled");

  property p_ms;
    in_valid && st_q.ms_en[0] && in_data[1] == '0 && st_q.ieq[0] == `MLM_UNITY &&
      st_q.ieq[1] == `MLM_UNITY |=> st_q.src[0] == st_q.src[1];
  endproperty
  a_ms: assert property (p_ms) else $error("mid not sent to both sides");

  property p_copy;
    wr_en && addr == `MLM_A_SUBMIX && wr_data[`MLM_B_COPY] && !wr_data[`MLM_B_CLEAR] &&
      int'(wr_data[`MLM_F_SRC +: 4]) < NO
      |=> st_q.gain_p[int'($past(wr_data[`MLM_F_SRC +: 4]))*NS+NS-1] ==
        $past(st_q.gain_p[int'(wr_data[`MLM_F_SRC +: 4])*NS+NS-1]);
  endproperty
  a_copy: assert property (p_copy) else $error("copy changed the source");

  property p_copy_dst;
    wr_en && addr == `MLM_A_SUBMIX && wr_data[`MLM_B_COPY] && !wr_data[`MLM_B_CLEAR] &&
      int'(wr_data[`MLM_F_SRC +: 4]) < NO && int'(wr_data[`MLM_F_DST +: 4]) < NO
      |=> st_q.gain_p[int'($past(wr_data[`MLM_F_DST +: 4]))*NS] ==
        $past(st_q.gain_p[int'(wr_data[`MLM_F_SRC +: 4])*NS]);
  endproperty
  a_copy_dst: assert property (p_copy_dst) else $error("copy missed the target");

  property p_clear;
    wr_en && addr == `MLM_A_SUBMIX && wr_data[`MLM_B_CLEAR] && wr_data[7:4] == 4'h0
      |=> st_q.gain_p[0] == '0 && st_q.gain_p[NS-1] == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left a routing");

  property p_live;
    !in_valid |=> $stable(st_q.gain_l) && $stable(st_q.lb_l);
  endproperty
  a_live: assert property (p_live) else $error("settings changed inside a sample");

  property p_apply;
    in_valid |=> st_q.gain_l == $past(st_q.gain_p);
  endproperty
  a_apply: assert property (p_apply) else $error("pending gains not applied");

  property p_lb_latch;
    in_valid |=> st_q.lb_l == $past(st_q.lb_p);
  endproperty
  a_lb_latch: assert property (p_lb_latch) else $error("loopback not taken at the sample");

  property p_out_hold;
    !st_q.v1 |=> $stable(out_data) && $stable(rec_data);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved between samples");

  property p_src_in;
    in_valid && !st_q.ms_en[0] && st_q.ieq[0] == `MLM_UNITY
      |=> st_q.src[0] == $past(in_data[0]);
  endproperty
  a_src_in: assert property (p_src_in) else $error("input lost to the mixer");

  property p_gain_wr;
    wr_en && in_rng(addr, `MLM_A_GAIN, NX)
      |=> st_q.gain_p[$past(addr) - `MLM_A_GAIN] == $past(wr_data[`MLM_GW-1:0]);
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("crosspoint gain not stored");

  property p_ms_wr;
    wr_en && addr == `MLM_A_MS |=> st_q.ms_en == $past(wr_data[NPR-1:0]);
  endproperty
  a_ms_wr: assert property (p_ms_wr) else $error("mid/side enable not stored");

  property p_clear_all;
    wr_en && addr == `MLM_A_SUBMIX && wr_data[`MLM_B_CLEAR] &&
      int'(wr_data[`MLM_F_DST +: 4]) < NO
      |=> st_q.gain_p[int'($past(wr_data[`MLM_F_DST +: 4]))*NS+NS/2] == '0;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear missed a routing");

  property p_rd_zero;
    !rd_en |=> rd_data == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside its cycle"); // read port

  property p_cnt;
    in_valid |=> st_q.cnt == $past(st_q.cnt) + 16'h1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("sample count missed a boundary"); // status count
endmodule

// File: sim/mlm_host.sv
// host software model: drives the register port of the mixer
`timescale 1ns/10ps
module mlm_host (
  input wire logic clk, // mixer clock
  output logic [7:0] addr, // register word address
  output logic [31:0] wr_data, // register write data
  output logic wr_en, // write strobe
  output logic rd_en // read strobe
);
  // idle bus at time zero
  initial begin
    addr = 8'h00;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  // one write cycle; gain, pan and submix commands all travel this way
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    // released bus shows the inverse so stale values never look valid
    addr <= ~a;
    wr_data <= ~d;
  endtask

  // one read cycle; data is taken by the bench monitor one edge later
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
  endtask
endmodule

// File: sim/mlm_mixer_bench.sv
// self-checking bench of the crosspoint mixer with a reference of the datapath
`timescale 1ns/10ps
`include "mlm_cfg.svh"
module mlm_mixer_bench;
  logic clk, rst, in_valid, wr_en, rd_en, out_valid, rd_seen;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0][`MLM_SW-1:0] in_data, pb_data, rec_data;
  logic [5:0][`MLM_SW-1:0] out_data;
  logic [31:0] rq[$];
  logic [239:0] oq[$];
  longint g[6][8], ieq[4], oeq[6];
  logic [3:0] lb, ms;
  logic ipr, z1;
  int miscompares, tests_run, ns;

  mlm_host i_host (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en));
  mlm_mixer #(.NI(4), .NP(4), .NO(6)) i_dut (.clk(clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .in_valid(in_valid), .in_data(in_data), .pb_data(pb_data), .out_valid(out_valid),
    .out_data(out_data), .rec_data(rec_data));

  // 250 mhz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic close_out();
    // an expectation never answered is a mismatch too, so a silent design cannot pass
    if (rq.size() != 0 || oq.size() != 0) miscompares++;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t read got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_samp(input logic [239:0] got, input logic [239:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t sample got %h exp %h", $time, got, exp);
    end
  endtask

  // reference datapath; inputs are multiples of four so eq and halving stay exact
  task automatic calc(input logic [3:0][23:0] iv, input logic [3:0][23:0] pv,
                      output logic [5:0][23:0] ov, output logic [3:0][23:0] rv);
    longint s[8], m[8], a;
    for (int i = 0; i < 8; i++) s[i] = (i < 4) ? longint'($signed(iv[i])) : longint'($signed(pv[i-4]));
    for (int i = 0; i < 8; i++) m[i] = ms[i/2] ? ((i % 2) ? s[i-1] - s[i] : s[i] + s[i+1]) : s[i];
    for (int i = 0; i < 4; i++) m[i] = (m[i] * ieq[i]) >>> 14;
    for (int o = 0; o < 6; o++) begin
      a = 0;
      for (int i = 0; i < 8; i++) a += (m[i] * g[o][i]) >>> 14;
      a = (a * oeq[o]) >>> 14;
      ov[o] = a[23:0];
    end
    for (int i = 0; i < 4; i++) rv[i] = lb[i] ? ov[i] : (ipr ? m[i][23:0] : iv[i]);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.wr(a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    i_host.rd(a);
  endtask

  task automatic sg(input int o, input int s, input logic [15:0] v);
    wr(8'(`MLM_A_GAIN + o * 8 + s), {16'h0, v});
    g[o][s] = longint'($signed(v));
  endtask

  // one random sample; expectation noted before it is sent
  task automatic send();
    logic [3:0][23:0] iv, pv, rv;
    logic [5:0][23:0] ov;
    for (int i = 0; i < 4; i++) begin
      iv[i] = 24'(($urandom_range(0, 8191) - 4096) * 4);
      pv[i] = 24'(($urandom_range(0, 8191) - 4096) * 4);
    end
    // a silent right input makes the mid reach both sides unchanged
    if (z1) iv[1] = '0;
    ns++;
    calc(iv, pv, ov, rv);
    oq.push_back({ov, rv});
    @(posedge clk);
    in_valid <= 1'b1;
    in_data <= iv;
    pb_data <= pv;
    @(posedge clk);
    in_valid <= 1'b0;
  endtask

  // monitor: read data one edge after the strobe, samples on out_valid
  always @(posedge clk) begin
    if (rd_seen) cmp_word(rd_data, rq.pop_front());
    else if (rst === 1'b0) cmp_word(rd_data, 32'h0);
    rd_seen = rd_en;
    if (out_valid === 1'b1) cmp_samp({out_data, rec_data}, oq.pop_front());
  end

  // hang guard, far beyond the fewer than a hundred cycles of the run
  initial begin
    #20000;
    miscompares++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    in_valid = 1'b0;
    in_data = '0;
    pb_data = '0;
    rd_seen = 1'b0;
    lb = 4'h0;
    ms = 4'h0;
    ipr = 1'b0;
    z1 = 1'b0;
    ns = 0;
    for (int o = 0; o < 6; o++) for (int s = 0; s < 8; s++) g[o][s] = 0;
    for (int i = 0; i < 6; i++) oeq[i] = 16384;
    for (int i = 0; i < 4; i++) ieq[i] = 16384;
    void'($urandom(32'hbd10e069));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // reset values and an unmapped place
    rd(`MLM_A_CTRL, 32'h0);
    rd(`MLM_A_LOOPBACK, 32'h0);
    rd(`MLM_A_IEQ + 8'h1, 32'h4000);
    rd(`MLM_A_OEQ + 8'h5, 32'h4000);
    rd(8'h3f, 32'h0);
    // individual crosspoint gains, negative one among them
    sg(0, 0, 16'h2000);
    sg(1, 4, 16'h4000);
    sg(2, 0, 16'h4000);
    sg(3, 7, 16'hc000);
    send();
    // loopback on output 0 and a phone output, output eq set
    wr(`MLM_A_LOOPBACK, 32'h21);
    lb = 4'h1;
    rd(`MLM_A_LOOPBACK, 32'h1);
    wr(`MLM_A_OEQ, 32'h2000);
    oeq[0] = 8192;
    send();
    // input processing in record with loopback active
    wr(`MLM_A_CTRL, 32'h1);
    ipr = 1'b1;
    wr(`MLM_A_IEQ + 8'h0, 32'h2000);
    ieq[0] = 8192;
    send();
    wr(`MLM_A_LOOPBACK, 32'hf);
    lb = 4'hf;
    send();
    // mid/side on input pair 0 and playback pair 0, processed record without loopback
    wr(`MLM_A_IEQ + 8'h0, 32'h4000);
    ieq[0] = 16384;
    wr(`MLM_A_LOOPBACK, 32'h0);
    lb = 4'h0;
    wr(`MLM_A_MS, 32'h5);
    ms = 4'h5;
    send();
    z1 = 1'b1;
    send();
    z1 = 1'b0;
    // copy output 0 onto output 5, then clear output 0
    wr(`MLM_A_SUBMIX, 32'h150);
    for (int s = 0; s < 8; s++) g[5][s] = g[0][s];
    rd(`MLM_A_GAIN + 8'h28, 32'h2000);
    wr(`MLM_A_SUBMIX, 32'h200);
    for (int s = 0; s < 8; s++) g[0][s] = 0;
    rd(`MLM_A_GAIN, 32'h0);
    // host gain with pan near centre, input 2 onto output pair 1
    wr(`MLM_A_DMON, 32'h12804000);
    g[2][2] = 8128;
    g[3][2] = 8192;
    rd(`MLM_A_GAIN + 8'h12, 32'h1fc0);
    rd(`MLM_A_GAIN + 8'h1a, 32'h2000);
    send();
    // status: last command was the host gain and pan, count of all samples sent
    rd(`MLM_A_STATUS, {14'h0, 2'h3, 16'(ns)});
    repeat (6) @(posedge clk);
    close_out();
  end
endmodule
